//--- design/stpg_crc_byte.sv
// stpg_crc_byte: one byte step of the reflected Ethernet CRC-32
`timescale 1ns/1ps
module stpg_crc_byte (
    // running value and byte
    input wire logic [31:0] i_crc,
    input wire logic [7:0] i_byte,
    // next value
    output logic [31:0] o_crc
);
    always_comb begin
        logic [31:0] c;
        c = i_crc ^ {24'h000000, i_byte};
        for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ stpg_pkg::CRC_POLY) : (c >> 1);
        end
        o_crc = c;
    end
endmodule // stpg_crc_byte

//--- design/stpg_gate.sv
// stpg_gate: port state gating, learning gate, flush and tail tag paths
// What this block does
// - port 3 is processor, never gated
// - ports 1, 2 hold tx, rx, learn-disable
// - rx and tx off: drop user traffic, keep override
// - learn disable blocks source address learning
// - learning state learns, forwards processor traffic only
// - forwarding state forwards and learns normally
// - tagged host frames reach non-transmitting ports
// - flush bits purge port entries, both tables
// - tail tag active only with enable bit
// - tail tag only on port 3 interface
// - tag bits 1:0 select destination
// - tag bits 3:2 give frame priority
// - egress tag bit 0 names source port
// - upper tag bits ignored
// - strip tag before network transmit
//
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module stpg_gate #(
    parameter int unsigned NPORTS = 2
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // forwarding decision
    input wire logic i_fwd_req,
    input wire logic [1:0] i_fwd_src,
    input wire logic [2:0] i_fwd_dst,
    input wire logic i_fwd_override,
    input wire logic i_fwd_directed,
    output logic o_fwd_valid,
    output logic [2:0] o_fwd_mask,
    // learning gate
    input wire logic i_learn_req,
    input wire logic [1:0] i_learn_src,
    output logic o_learn_valid,
    output logic o_learn_grant,
    // table flush
    output logic o_flush_dyn,
    output logic o_flush_sta,
    output logic [1:0] o_flush_ports,
    // port 3 receive stream (from processor)
    input wire logic [7:0] i_p3_rx_data,
    input wire logic i_p3_rx_valid,
    input wire logic i_p3_rx_last,
    // host frame toward network
    output logic [7:0] o_h2n_data,
    output logic o_h2n_valid,
    output logic o_h2n_last,
    output logic [1:0] o_h2n_dir,
    output logic [1:0] o_h2n_prio,
    // network frame toward host
    input wire logic [7:0] i_n2h_data,
    input wire logic i_n2h_valid,
    input wire logic i_n2h_last,
    input wire logic i_n2h_src,
    // port 3 transmit stream (to processor)
    output logic [7:0] o_p3_tx_data,
    output logic o_p3_tx_valid,
    output logic o_p3_tx_last
);
    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [7:0] pctl_q [NPORTS];
    logic [7:0] pctl_d [NPORTS];
    logic [NPORTS-1:0] tx_en, rx_en, learn_dis;
    logic tail_en_q, tail_en_d;
    logic dph_wr_q;
    logic [31:0] dph_addr_q;
    logic aph;
    logic [31:0] rd_d;

    assign aph = i_hsel && i_htrans[1] && i_hready;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            dph_wr_q <= 1'b0;
            dph_addr_q <= 32'h00000000;
        end else if (i_hready) begin
            dph_wr_q <= aph && i_hwrite;
            dph_addr_q <= i_haddr;
        end
    end

    generate
        for (genvar p = 0; p < NPORTS; p++) begin : g_port
            assign pctl_d[p] = (dph_wr_q && dph_addr_q ==
                (p == 0 ? stpg_pkg::ADDR_P1_CTRL : stpg_pkg::ADDR_P2_CTRL)) ?
                {5'h00, i_hwdata[2:0]} : pctl_q[p];
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    pctl_q[p] <= stpg_pkg::PORT_CTRL_RST;
                end else begin
                    pctl_q[p] <= pctl_d[p];
                end
            end
            assign tx_en[p] = pctl_q[p][stpg_pkg::TX_EN_BIT];
            assign rx_en[p] = pctl_q[p][stpg_pkg::RX_EN_BIT];
            assign learn_dis[p] = pctl_q[p][stpg_pkg::LEARN_DIS_BIT];
        end
    endgenerate

    assign tail_en_d = (dph_wr_q && dph_addr_q == stpg_pkg::ADDR_GLOBAL3) ?
        i_hwdata[stpg_pkg::TAIL_EN_BIT] : tail_en_q;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            tail_en_q <= stpg_pkg::TAIL_EN_RST;
        end else begin
            tail_en_q <= tail_en_d;
        end
    end

    // read mux sees this cycle's write, so back-to-back reads are fresh
    always_comb begin
        rd_d = 32'h00000000;
        case (i_haddr)
            stpg_pkg::ADDR_GLOBAL3: rd_d[stpg_pkg::TAIL_EN_BIT] = tail_en_d;
            stpg_pkg::ADDR_P1_CTRL: rd_d[7:0] = pctl_d[0];
            stpg_pkg::ADDR_P2_CTRL: rd_d[7:0] = pctl_d[1];
            default: rd_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        o_hreadyout <= 1'b1;
        o_hresp <= 1'b0;
        if (i_rst) begin
            o_hrdata <= 32'h00000000;
        end else if (aph && !i_hwrite) begin
            o_hrdata <= rd_d;
        end
    end

    // ----------------------------------------------------------------
    // flush
    // ----------------------------------------------------------------
    // self-clearing flush strobes
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_flush_dyn <= 1'b0;
            o_flush_sta <= 1'b0;
            o_flush_ports <= 2'h0;
        end else begin
            o_flush_dyn <= 1'b0;
            o_flush_sta <= 1'b0;
            if (dph_wr_q && dph_addr_q == stpg_pkg::ADDR_GLOBAL2) begin
                o_flush_dyn <= i_hwdata[stpg_pkg::FLUSH_DYN_BIT];
                o_flush_sta <= i_hwdata[stpg_pkg::FLUSH_STA_BIT];
                o_flush_ports <= learn_dis;
            end
        end
    end

    // ----------------------------------------------------------------
    // forwarding and learning gate
    // ----------------------------------------------------------------
    logic [2:0] fwd_d;
    logic src_net;
    logic src_idx;

    assign src_net = (i_fwd_src == stpg_pkg::SRC_PORT1) || (i_fwd_src == stpg_pkg::SRC_PORT2);
    assign src_idx = (i_fwd_src == stpg_pkg::SRC_PORT2);

    always_comb begin
        fwd_d = 3'h0;
        if (src_net) begin
            // closed receive: only override frames to host
            if (!rx_en[src_idx]) begin
                fwd_d = i_fwd_override ? 3'h4 : 3'h0;
            end else begin
                fwd_d = i_fwd_dst & {1'b1, tx_en};
            end
        end else if (i_fwd_src == stpg_pkg::SRC_HOST) begin
            // directed host frames ignore tx enable
            fwd_d = i_fwd_dst & (i_fwd_directed ? 3'h3 : {1'b0, tx_en});
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_fwd_valid <= 1'b0;
            o_fwd_mask <= 3'h0;
        end else begin
            o_fwd_valid <= i_fwd_req;
            if (i_fwd_req) begin
                o_fwd_mask <= fwd_d;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_learn_valid <= 1'b0;
            o_learn_grant <= 1'b0;
        end else begin
            o_learn_valid <= i_learn_req;
            o_learn_grant <= i_learn_req && ((i_learn_src == stpg_pkg::SRC_HOST) ||
                ((i_learn_src == stpg_pkg::SRC_PORT1) && !learn_dis[0]) ||
                ((i_learn_src == stpg_pkg::SRC_PORT2) && !learn_dis[1]));
        end
    end

    // ----------------------------------------------------------------
    // host to network: strip tag, new fcs
    // ----------------------------------------------------------------
    localparam int HD = stpg_pkg::FCS_BYTES + 1;
    logic [7:0] h_line_q [HD];
    logic [2:0] h_fill_q;
    logic [2:0] h_left_q;
    logic h_fcs_q;
    logic [31:0] h_crc_q, h_crc_nx;
    logic h_busy, h_take, h_pay;
    logic [7:0] h_tag;

    assign h_busy = (h_left_q != 3'h0);
    assign h_take = i_p3_rx_valid && !h_busy;
    assign h_pay = h_take && (h_fill_q == 3'(HD));
    assign h_tag = h_line_q[HD-2];

    stpg_crc_byte u_h_crc (
        .i_crc(h_crc_q),
        .i_byte(h_line_q[HD-1]),
        .o_crc(h_crc_nx)
    );

    // tag window only on the port 3 stream
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            for (int i = 0; i < HD; i++) h_line_q[i] <= 8'h00;
            h_fill_q <= 3'h0;
            h_left_q <= 3'h0;
            h_fcs_q <= 1'b0;
        end else begin
            if (h_take || (h_busy && !h_fcs_q)) begin
                h_line_q[0] <= h_take ? i_p3_rx_data : 8'h00;
                for (int i = 1; i < HD; i++) h_line_q[i] <= h_line_q[i-1];
            end
            if (h_take) begin
                h_fill_q <= i_p3_rx_last ? 3'h0 : (h_pay ? h_fill_q : h_fill_q + 3'h1);
            end
            if (h_take && i_p3_rx_last) begin
                // drop tag and old fcs, or pass whole tail
                h_left_q <= tail_en_q ? 3'(stpg_pkg::FCS_BYTES) : 3'(HD);
                h_fcs_q <= tail_en_q;
            end else if (h_busy) begin
                h_left_q <= h_left_q - 3'h1;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            h_crc_q <= stpg_pkg::CRC_INIT;
        end else if (h_busy) begin
            h_crc_q <= (h_left_q == 3'h1) ? stpg_pkg::CRC_INIT : (h_crc_q >> 8);
        end else if (h_pay) begin
            h_crc_q <= h_crc_nx;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_h2n_data <= 8'h00;
            o_h2n_valid <= 1'b0;
            o_h2n_last <= 1'b0;
            o_h2n_dir <= stpg_pkg::TAG_DST_LOOKUP;
            o_h2n_prio <= stpg_pkg::PRIO_DEFAULT;
        end else begin
            o_h2n_valid <= h_busy || h_pay;
            o_h2n_last <= (h_left_q == 3'h1);
            o_h2n_data <= (h_busy && h_fcs_q) ? ~h_crc_q[7:0] : h_line_q[HD-1];
            if (h_take && i_p3_rx_last) begin
                // only low four tag bits used
                o_h2n_dir <= tail_en_q ? h_tag[stpg_pkg::TAG_DST_LSB +: 2] :
                    stpg_pkg::TAG_DST_LOOKUP;
                o_h2n_prio <= tail_en_q ? h_tag[stpg_pkg::TAG_PRIO_LSB +: 2] :
                    stpg_pkg::PRIO_DEFAULT;
            end
        end
    end

    // ----------------------------------------------------------------
    // network to host: insert tag, new fcs
    // ----------------------------------------------------------------
    localparam int ND = stpg_pkg::FCS_BYTES;
    logic [7:0] n_line_q [ND];
    logic [2:0] n_fill_q;
    logic [2:0] n_left_q;
    logic n_tag_q;
    logic n_src_q;
    logic [31:0] n_crc_q, n_crc_nx;
    logic n_busy, n_take, n_pay, n_tagcyc;
    logic [7:0] n_tagbyte, n_crc_in;

    assign n_busy = (n_left_q != 3'h0);
    assign n_take = i_n2h_valid && !n_busy;
    assign n_pay = n_take && (n_fill_q == 3'(ND));
    assign n_tagcyc = n_busy && n_tag_q && (n_left_q == 3'(ND + 1));
    // source port in bit 0, rest zero
    assign n_tagbyte = {7'h00, n_src_q};
    assign n_crc_in = n_busy ? n_tagbyte : n_line_q[ND-1];

    stpg_crc_byte u_n_crc (
        .i_crc(n_crc_q),
        .i_byte(n_crc_in),
        .o_crc(n_crc_nx)
    );

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            for (int i = 0; i < ND; i++) n_line_q[i] <= 8'h00;
            n_fill_q <= 3'h0;
            n_left_q <= 3'h0;
            n_tag_q <= 1'b0;
            n_src_q <= 1'b0;
        end else begin
            if (n_take || (n_busy && !n_tag_q)) begin
                n_line_q[0] <= n_take ? i_n2h_data : 8'h00;
                for (int i = 1; i < ND; i++) n_line_q[i] <= n_line_q[i-1];
            end
            if (n_take) begin
                n_fill_q <= i_n2h_last ? 3'h0 : (n_pay ? n_fill_q : n_fill_q + 3'h1);
            end
            if (n_take && i_n2h_last) begin
                // tag plus new fcs, or original fcs
                n_left_q <= tail_en_q ? 3'(ND + 1) : 3'(ND);
                n_tag_q <= tail_en_q;
                n_src_q <= i_n2h_src;
            end else if (n_busy) begin
                n_left_q <= n_left_q - 3'h1;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            n_crc_q <= stpg_pkg::CRC_INIT;
        end else if (n_busy && n_left_q == 3'h1) begin
            n_crc_q <= stpg_pkg::CRC_INIT;
        end else if (n_tagcyc || n_pay) begin
            n_crc_q <= n_crc_nx;
        end else if (n_busy) begin
            n_crc_q <= n_crc_q >> 8;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_p3_tx_data <= 8'h00;
            o_p3_tx_valid <= 1'b0;
            o_p3_tx_last <= 1'b0;
        end else begin
            o_p3_tx_valid <= n_busy || n_pay;
            o_p3_tx_last <= (n_left_q == 3'h1);
            o_p3_tx_data <= n_tagcyc ? n_tagbyte :
                ((n_busy && n_tag_q) ? ~n_crc_q[7:0] : n_line_q[ND-1]);
        end
    end

endmodule // stpg_gate

//--- design/stpg_pkg.sv
// stpg_pkg: shared constants for the spanning tree gate and tail tag block
package stpg_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int REG_GLOBAL2_IDX = 2;
    localparam int REG_GLOBAL3_IDX = 3;
    localparam int REG_P1_CTRL_IDX = 18;
    localparam int REG_P2_CTRL_IDX = 34;
    localparam logic [31:0] ADDR_GLOBAL2 = 32'(REG_GLOBAL2_IDX * 4);
    localparam logic [31:0] ADDR_GLOBAL3 = 32'(REG_GLOBAL3_IDX * 4);
    localparam logic [31:0] ADDR_P1_CTRL = 32'(REG_P1_CTRL_IDX * 4);
    localparam logic [31:0] ADDR_P2_CTRL = 32'(REG_P2_CTRL_IDX * 4);

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int FLUSH_DYN_BIT = 5;
    localparam int FLUSH_STA_BIT = 4;
    localparam int TAIL_EN_BIT = 6;
    localparam int TX_EN_BIT = 2;
    localparam int RX_EN_BIT = 1;
    localparam int LEARN_DIS_BIT = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PORT_CTRL_RST = 8'h06;
    localparam logic TAIL_EN_RST = 1'b0;

    // ----------------------------------------------------------------
    // tail tag and frame check
    // ----------------------------------------------------------------
    localparam int TAG_DST_LSB = 0;
    localparam int TAG_PRIO_LSB = 2;
    localparam logic [1:0] TAG_DST_LOOKUP = 2'h0;
    localparam logic [1:0] PRIO_DEFAULT = 2'h0;
    localparam int FCS_BYTES = 4;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;

    // ----------------------------------------------------------------
    // source codes on the forwarding request
    // ----------------------------------------------------------------
    localparam logic [1:0] SRC_PORT1 = 2'h1;
    localparam logic [1:0] SRC_PORT2 = 2'h2;
    localparam logic [1:0] SRC_HOST = 2'h3;

endpackage

//--- tb/stpg_gate_monitor.sv
// stpg_gate_monitor: port-level checks for the gate and tail tag block
`timescale 1ns/1ps
module stpg_gate_monitor (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // forwarding and learning
    input wire logic i_fwd_req,
    input wire logic [1:0] i_fwd_src,
    input wire logic [2:0] i_fwd_dst,
    input wire logic i_fwd_directed,
    input wire logic o_fwd_valid,
    input wire logic [2:0] o_fwd_mask,
    input wire logic i_learn_req,
    input wire logic [1:0] i_learn_src,
    input wire logic o_learn_valid,
    input wire logic o_learn_grant,
    // flush and host stream
    input wire logic o_flush_dyn,
    input wire logic o_flush_sta,
    input wire logic o_h2n_valid,
    input wire logic o_h2n_last
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    // ----
    // request and flush sequences
    // ----
    sequence s_host_req;
        i_fwd_req && i_fwd_src == stpg_pkg::SRC_HOST;
    endsequence
    sequence s_net_req;
        i_fwd_req && (i_fwd_src == stpg_pkg::SRC_PORT1 || i_fwd_src == stpg_pkg::SRC_PORT2);
    endsequence
    sequence s_flush;
        o_flush_dyn || o_flush_sta;
    endsequence
    // ----
    // properties
    // ----
    property p_fwd_answer;
        i_fwd_req |=> o_fwd_valid;
    endproperty
    a_fwd_answer: assert property (p_fwd_answer)
        else $error("forward answer missing");
    property p_fwd_quiet;
        !i_fwd_req |=> !o_fwd_valid;
    endproperty
    a_fwd_quiet: assert property (p_fwd_quiet)
        else $error("stray forward answer");
    property p_directed;
        s_host_req ##0 i_fwd_directed |=> o_fwd_mask == ($past(i_fwd_dst) & 3'h3);
    endproperty
    a_directed: assert property (p_directed)
        else $error("directed mask wrong");
    property p_no_loop;
        s_host_req |=> !o_fwd_mask[2];
    endproperty
    a_no_loop: assert property (p_no_loop)
        else $error("host frame sent back to host");
    property p_net_subset;
        s_net_req |=> (o_fwd_mask & ~($past(i_fwd_dst) | 3'h4)) == 3'h0;
    endproperty
    a_net_subset: assert property (p_net_subset)
        else $error("net mask outside lookup");
    property p_no_src;
        i_fwd_req && i_fwd_src == 2'h0 |=> o_fwd_mask == 3'h0;
    endproperty
    a_no_src: assert property (p_no_src)
        else $error("frame without source forwarded");
    property p_learn_host;
        i_learn_req && i_learn_src == stpg_pkg::SRC_HOST |=> o_learn_valid && o_learn_grant;
    endproperty
    a_learn_host: assert property (p_learn_host)
        else $error("host learn refused");
    property p_learn_idle;
        !i_learn_req |=> !o_learn_valid && !o_learn_grant;
    endproperty
    a_learn_idle: assert property (p_learn_idle)
        else $error("stray learn answer");
    property p_flush_pulse;
        s_flush |=> !o_flush_dyn && !o_flush_sta;
    endproperty
    a_flush_pulse: assert property (p_flush_pulse)
        else $error("flush strobe too long");
    property p_last_end;
        o_h2n_last |-> o_h2n_valid ##1 !o_h2n_last;
    endproperty
    a_last_end: assert property (p_last_end)
        else $error("frame end marker malformed");
endmodule // stpg_gate_monitor

bind stpg_gate stpg_gate_monitor mon_u (.*);

//--- tb/stpg_host_model.sv
// stpg_host_model: processor on port 3, frames in and out
`timescale 1ns/1ps
module stpg_host_model (
    // clock
    input wire logic i_mclk,
    // frames to the switch
    output logic [7:0] o_data,
    output logic o_valid,
    output logic o_last,
    // frames from the switch
    input wire logic [7:0] i_data,
    input wire logic i_valid,
    input wire logic i_last
);
    logic [7:0] rx_q[$];
    initial begin
        o_data = 8'h00;
        o_valid = 1'b0;
        o_last = 1'b0;
    end
    // frame with or without tail tag, one byte per cycle
    task automatic send(input logic [7:0] b[$]);
        foreach (b[i]) begin
            @(posedge i_mclk);
            o_data <= b[i];
            o_valid <= 1'b1;
            o_last <= (i == b.size() - 1);
        end
        @(posedge i_mclk);
        o_valid <= 1'b0;
        o_last <= 1'b0;
        o_data <= ~o_data;
    endtask
    // all returned bytes kept for judging
    always @(posedge i_mclk) begin
        if (i_valid) begin
            rx_q.push_back(i_data);
        end
    end
endmodule // stpg_host_model

//--- tb/tb_spanning_tree_port_gate_tail_tag.sv
// tb_spanning_tree_port_gate_tail_tag: self-checking bench for the gate block
`timescale 1ns/1ps
module tb_spanning_tree_port_gate_tail_tag;
    typedef logic [7:0] stpg_bq_t[$];
    logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hrdata;
    logic hready, hresp;
    logic fwd_req = 1'b0, fwd_ov = 1'b0, fwd_dr = 1'b0, learn_req = 1'b0, fwd_valid;
    logic [1:0] fwd_src = 2'h0, learn_src = 2'h0;
    logic [2:0] fwd_dst = 3'h0, fwd_mask;
    logic learn_valid, learn_grant, flush_dyn, flush_sta;
    logic [1:0] flush_ports, h2n_dir, h2n_prio;
    logic [7:0] p3rx_d, h2n_d, p3tx_d;
    logic p3rx_v, p3rx_l, h2n_v, h2n_l, p3tx_v, p3tx_l;
    logic [7:0] n2h_d = 8'h0;
    logic n2h_v = 1'b0, n2h_l = 1'b0, n2h_src = 1'b0;
    int mismatches = 0, check_count = 0, n_dyn = 0, n_sta = 0, n_hl = 0;
    stpg_bq_t h2n_q;

    always #2.5 mclk = ~mclk;

    stpg_gate dut_u (
        .i_mclk(mclk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_fwd_req(fwd_req),
        .i_fwd_src(fwd_src), .i_fwd_dst(fwd_dst), .i_fwd_override(fwd_ov),
        .i_fwd_directed(fwd_dr), .o_fwd_valid(fwd_valid), .o_fwd_mask(fwd_mask),
        .i_learn_req(learn_req), .i_learn_src(learn_src), .o_learn_valid(learn_valid),
        .o_learn_grant(learn_grant), .o_flush_dyn(flush_dyn), .o_flush_sta(flush_sta),
        .o_flush_ports(flush_ports), .i_p3_rx_data(p3rx_d), .i_p3_rx_valid(p3rx_v),
        .i_p3_rx_last(p3rx_l), .o_h2n_data(h2n_d), .o_h2n_valid(h2n_v), .o_h2n_last(h2n_l),
        .o_h2n_dir(h2n_dir), .o_h2n_prio(h2n_prio), .i_n2h_data(n2h_d), .i_n2h_valid(n2h_v),
        .i_n2h_last(n2h_l), .i_n2h_src(n2h_src), .o_p3_tx_data(p3tx_d),
        .o_p3_tx_valid(p3tx_v), .o_p3_tx_last(p3tx_l)
    );
    stpg_host_model host_u (
        .i_mclk(mclk), .o_data(p3rx_d), .o_valid(p3rx_v), .o_last(p3rx_l),
        .i_data(p3tx_d), .i_valid(p3tx_v), .i_last(p3tx_l)
    );

    always @(posedge mclk) begin
        if (h2n_v) h2n_q.push_back(h2n_d);
        if (h2n_l || p3tx_l) n_hl++;
        if (flush_dyn) n_dyn++;
        if (flush_sta) n_sta++;
    end
    // ----
    // shared tasks
    // ----
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        chk(x, e);
        chk(32'(hresp), 32'h0);
    endtask
    task automatic fwd(input logic [1:0] s, input logic [2:0] d, input logic o,
                       input logic dr, input logic [2:0] e);
        @(posedge mclk);
        fwd_req <= 1'b1;
        fwd_src <= s;
        fwd_dst <= d;
        fwd_ov <= o;
        fwd_dr <= dr;
        @(posedge mclk);
        fwd_req <= 1'b0;
        #1;
        chk(32'({fwd_valid, fwd_mask}), 32'({1'b1, e}));
    endtask
    task automatic lrn(input logic [1:0] s, input logic g);
        @(posedge mclk);
        learn_req <= 1'b1;
        learn_src <= s;
        @(posedge mclk);
        learn_req <= 1'b0;
        #1;
        chk(32'({learn_valid, learn_grant}), 32'({1'b1, g}));
    endtask
    function automatic stpg_bq_t with_fcs(input stpg_bq_t b);
        logic [31:0] c;
        c = stpg_pkg::CRC_INIT;
        foreach (b[i]) begin
            c = c ^ 32'(b[i]);
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ stpg_pkg::CRC_POLY : c >> 1;
        end
        c = ~c;
        for (int k = 0; k < 4; k++) b.push_back(c[8*k +: 8]);
        return b;
    endfunction
    task automatic cmp(input stpg_bq_t g, input stpg_bq_t e);
        chk(32'(g.size()), 32'(e.size()));
        foreach (e[i]) chk(32'(g[i]), 32'(e[i]));
    endtask
    task automatic net_send(input logic s, input stpg_bq_t b);
        foreach (b[i]) begin
            @(posedge mclk);
            n2h_d <= b[i];
            n2h_v <= 1'b1;
            n2h_l <= (i == b.size() - 1);
            n2h_src <= s;
        end
        @(posedge mclk);
        n2h_v <= 1'b0;
        n2h_l <= 1'b0;
        n2h_d <= ~n2h_d;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_regs;
        rdc(stpg_pkg::ADDR_P1_CTRL, 32'h6);
        rdc(stpg_pkg::ADDR_P2_CTRL, 32'h6);
        rdc(stpg_pkg::ADDR_GLOBAL3, 32'h0);
        wr(32'hC8, 32'hFF);
        rdc(32'hC8, 32'h0);
        wr(stpg_pkg::ADDR_P1_CTRL, 32'hFFFFFF05);
        rdc(stpg_pkg::ADDR_P1_CTRL, 32'h5);
        wr(stpg_pkg::ADDR_P1_CTRL, 32'h6);
    endtask
    task automatic t_gate;
        fwd(stpg_pkg::SRC_PORT1, 3'h6, 1'b0, 1'b0, 3'h6);
        wr(stpg_pkg::ADDR_P2_CTRL, 32'h0);
        fwd(stpg_pkg::SRC_PORT2, 3'h5, 1'b0, 1'b0, 3'h0);
        fwd(stpg_pkg::SRC_PORT1, 3'h6, 1'b0, 1'b0, 3'h4);
        fwd(stpg_pkg::SRC_HOST, 3'h7, 1'b0, 1'b0, 3'h1);
        fwd(stpg_pkg::SRC_HOST, 3'h7, 1'b0, 1'b1, 3'h3);
        fwd(2'h0, 3'h7, 1'b0, 1'b0, 3'h0);
        lrn(stpg_pkg::SRC_PORT2, 1'b1);
        wr(stpg_pkg::ADDR_P2_CTRL, 32'h1);
        lrn(stpg_pkg::SRC_PORT2, 1'b0);
        fwd(stpg_pkg::SRC_PORT2, 3'h7, 1'b1, 1'b0, 3'h4);
        fwd(stpg_pkg::SRC_PORT2, 3'h7, 1'b0, 1'b0, 3'h0);
        lrn(stpg_pkg::SRC_HOST, 1'b1);
        lrn(stpg_pkg::SRC_PORT1, 1'b1);
    endtask
    task automatic t_flush;
        wr(stpg_pkg::ADDR_GLOBAL2, 32'h30);
        repeat (3) @(posedge mclk);
        chk(32'(n_dyn), 32'h1);
        chk(32'(n_sta), 32'h1);
        chk(32'(flush_ports), 32'h2);
        wr(stpg_pkg::ADDR_GLOBAL2, 32'h20);
        repeat (3) @(posedge mclk);
        chk(32'({n_dyn[3:0], n_sta[3:0]}), 32'h21);
        rdc(stpg_pkg::ADDR_GLOBAL2, 32'h0);
        wr(stpg_pkg::ADDR_P2_CTRL, 32'h6);
    endtask
    task automatic t_h2n(input logic on);
        stpg_bq_t pay, fr, ex;
        logic [7:0] tag;
        int base;
        pay = '{8'h55, 8'h01, 8'hFE, 8'h80, 8'h7F, 8'hAA};
        base = n_hl;
        for (int i = 0; i < 4; i++) begin
            tag = {4'hA, 2'(3 - i), 2'(i)};
            ex = with_fcs(pay);
            fr = on ? with_fcs({pay, tag}) : ex;
            h2n_q.delete();
            host_u.send(fr);
            repeat (12) @(posedge mclk);
            cmp(h2n_q, ex);
            chk(32'({h2n_prio, h2n_dir}), on ? 32'(tag[3:0]) : 32'h0);
        end
        chk(32'(n_hl - base), 32'h4);
    endtask
    task automatic t_n2h(input logic on);
        stpg_bq_t pay, ex;
        int base;
        pay = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9A};
        base = n_hl;
        for (int s = 0; s < 2; s++) begin
            host_u.rx_q.delete();
            net_send(1'(s), with_fcs(pay));
            repeat (12) @(posedge mclk);
            ex = with_fcs(pay);
            if (on) ex = with_fcs({pay, 8'(s)});
            cmp(host_u.rx_q, ex);
        end
        chk(32'(n_hl - base), 32'h2);
    endtask
    // ----
    // run control
    // ----
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #50000;
        mismatches++;
        $display("ERROR %0t: watchdog expired", $time);
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_gate();
        t_flush();
        wr(stpg_pkg::ADDR_GLOBAL3, 32'h40);
        rdc(stpg_pkg::ADDR_GLOBAL3, 32'h40);
        t_h2n(1'b1);
        t_n2h(1'b1);
        wr(stpg_pkg::ADDR_GLOBAL3, 32'h0);
        t_h2n(1'b0);
        t_n2h(1'b0);
        wrap_up();
    end
endmodule // tb_spanning_tree_port_gate_tail_tag
